/* File: include/ssm_pkg.sv */
// Package: offsets, field positions, reset values and carriers of the socket status/mask bank
package ssm_pkg;

   // ==========================================================================
   // Register byte offsets
   localparam logic [5:0]  SSM_OFF_EVENT    = 6'h00;        // Sticky socket event flags
   localparam logic [5:0]  SSM_OFF_MASK     = 6'h04;        // socket_interrupt_mask
   localparam logic [5:0]  SSM_OFF_STATE    = 6'h08;        // socket_live_state
   localparam logic [5:0]  SSM_OFF_FORCE    = 6'h0C;        // Force-event, write only

   // ==========================================================================
   // Mask and event field positions
   localparam int          SSM_PWR_BIT      = 3;            // Power cycle
   localparam int          SSM_CD_HI_BIT    = 2;            // Card detect two
   localparam int          SSM_CD_LO_BIT    = 1;            // Card detect one
   localparam int          SSM_CST_BIT      = 0;            // Card status change
   localparam int          SSM_MASK_W       = 4;            // Implemented mask width
   localparam logic [3:0]  SSM_MASK_RESET   = 4'h0;         // All events masked

   // ==========================================================================
   // Present-state field positions
   localparam int          SSM_ST_FUT_Y     = 31;           // socket_supplies_future_y
   localparam int          SSM_ST_FUT_X     = 30;           // socket_supplies_future_x
   localparam int          SSM_ST_LOW_V     = 29;           // socket_supplies_low_volt
   localparam int          SSM_ST_HIGH_V    = 28;           // socket_supplies_high_volt
   localparam int          SSM_ST_ZV        = 27;           // zoomed_video_capable
   localparam int          SSM_ST_CARD_LO   = 11;           // card_accepts_low_volt, 12 = x, 13 = y
   localparam int          SSM_ST_PWR       = 3;            // socket_powered_flag
   localparam int          SSM_ST_DET2      = 2;            // detect_two_level
   localparam int          SSM_ST_DET1      = 1;            // detect_one_level
   localparam int          SSM_ST_CST       = 0;            // card_status_level
   localparam logic [31:0] SSM_STATE_FIXED  = 32'h3000_0000; // Socket supply capability bits

   // ==========================================================================
   // Pin synchroniser
   localparam int          SSM_SYNC_STAGES  = 3;            // Flip-flops per pin
   localparam int          SSM_PINS         = 3;            // 0 detect one, 1 detect two, 2 status

   // ==========================================================================
   // Carriers
   typedef struct packed {
      logic        wr;                                      // Write strobe, one cycle
      logic        rd;                                      // Read strobe, one cycle
      logic [5:0]  addr;                                    // Byte offset
      logic [31:0] wdata;                                   // Write data
   } ssm_bus_req_t;

   typedef struct packed {
      logic        busy;                                    // Card identification running
      logic        insert_done;                             // Pulse: identification finished
      logic [2:0]  card_volts;                              // {future_y, future_x, low_volt}
      logic        cardbus;                                 // Card in socket is CardBus
   } ssm_ident_t;

   typedef struct packed {
      logic [SSM_PINS-1:0] sync0;                           // First synchroniser stage
      logic [SSM_PINS-1:0] sync1;                           // Second stage
      logic [SSM_PINS-1:0] sync2;                           // Third stage
      logic [SSM_PINS-1:0] lvl;                             // Filtered pin levels
      logic [1:0]          det_rep;                         // Reported detect levels
      logic                pwr_prev;                        // Last socket power state
      logic [3:0]          mask;                            // Interrupt enables
      logic [3:0]          event_f;                         // Sticky event flags
      logic                zv;                              // Zoomed video capable
      logic [2:0]          card_v;                          // Card voltage support
      logic [31:0]         rdata;                           // Read data
      logic                irq;                             // Status change interrupt
   } ssm_state_t;

   localparam ssm_state_t  SSM_STATE_RESET  = '0;           // Everything clear after reset

endpackage : ssm_pkg

/* File: src/ssm_regs.sv */
// Socket interrupt mask and live-state registers with event flags and interrupt
`timescale 1ns/1ps
`default_nettype none

module ssm_regs (
   input  wire logic                  i_clk,                       // 10 MHz host bus clock
   input  wire logic                  i_rst_n,                     // Synchronous reset, active low
   input  wire ssm_pkg::ssm_bus_req_t i_bus,                       // Register access request
   input  wire ssm_pkg::ssm_ident_t   i_ident,                     // Card identification results
   input  wire logic                  i_card_detect_one_n,         // Detect pin one, asynchronous
   input  wire logic                  i_card_detect_two_n,         // Detect pin two, asynchronous
   input  wire logic                  i_card_status_change,        // Card status pin, asynchronous
   input  wire logic                  i_socket_powered,            // Power state from socket control
   output logic [31:0]                o_rdata,                     // Read data, cycle after rd
   output logic                       o_status_change_interrupt    // Level interrupt
);
   import ssm_pkg::*;

   // ==========================================================================
   // Decoding helpers
   // Builds the live-state word from the current state
   function automatic logic [31:0] state_word(input ssm_state_t s);
      logic [31:0] w;
      w = SSM_STATE_FIXED;
      w[SSM_ST_ZV] = s.zv;
      w[SSM_ST_CARD_LO +: 3] = s.card_v;
      w[SSM_ST_PWR] = s.pwr_prev;
      w[SSM_ST_DET2] = s.det_rep[1];
      w[SSM_ST_DET1] = s.det_rep[0];
      w[SSM_ST_CST] = s.lvl[2];
      return w;
   endfunction : state_word

   // Register read multiplexer; unmapped and write-only offsets read zero
   function automatic logic [31:0] read_word(input ssm_state_t s, input logic [5:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      unique case (a)
         SSM_OFF_EVENT: w[3:0] = s.event_f;
         SSM_OFF_MASK:  w[3:0] = s.mask;
         SSM_OFF_STATE: w = state_word(s);
         default:       w = 32'h0000_0000;
      endcase
      return w;
   endfunction : read_word

   // ==========================================================================
   // State
   ssm_state_t q;                                                  // Registered state
   ssm_state_t d;                                                  // Next state
   logic       wr_mask;                                            // Mask register write
   logic       wr_force;                                           // Force register write
   logic [3:0] clr;                                                // Write-one-to-clear bits
   logic [3:0] hw_set;                                             // Hardware detected events
   logic [3:0] irq_en;                                             // Per-flag interrupt enable

   // ==========================================================================
   // Next-state logic
   always_comb begin
      d        = q;
      wr_mask  = i_bus.wr && (i_bus.addr == SSM_OFF_MASK);
      wr_force = i_bus.wr && (i_bus.addr == SSM_OFF_FORCE);
      clr      = (i_bus.wr && (i_bus.addr == SSM_OFF_EVENT)) ? i_bus.wdata[3:0] : 4'h0;

      // Three-stage pin synchronisers; a change counts once stages two and three agree
      d.sync0 = {i_card_status_change, i_card_detect_two_n, i_card_detect_one_n};
      d.sync1 = q.sync0;
      d.sync2 = q.sync1;
      for (int i = 0; i < SSM_PINS; i++) begin
         if (q.sync1[i] == q.sync2[i]) begin
            d.lvl[i] = q.sync2[i];
         end
      end

      // Detect levels freeze while the card is being identified, as the pins are reused then
      if (!i_ident.busy) begin
         d.det_rep = d.lvl[1:0];
      end

      d.pwr_prev = i_socket_powered;

      // Voltage support latched only at insertion or by a forced write
      if (i_ident.insert_done) begin
         d.card_v = i_ident.card_volts;
      end
      if (wr_force) begin
         d.card_v = i_bus.wdata[SSM_ST_CARD_LO +: 3];
         d.zv     = i_bus.wdata[SSM_ST_ZV];
      end

      // Hardware events; status pin edge sense depends on card type
      hw_set[SSM_PWR_BIT]   = (i_socket_powered != q.pwr_prev);
      hw_set[SSM_CD_HI_BIT] = (d.det_rep[1] != q.det_rep[1]);
      hw_set[SSM_CD_LO_BIT] = (d.det_rep[0] != q.det_rep[0]);
      hw_set[SSM_CST_BIT]   = i_ident.cardbus ? (d.lvl[2] & ~q.lvl[2])
                                              : (d.lvl[2] ^ q.lvl[2]);

      // Set beats clear so an event in the clearing cycle survives; mask is not consulted
      d.event_f = (q.event_f & ~clr) | hw_set | (wr_force ? i_bus.wdata[3:0] : 4'h0);

      // Only the four mask bits are stored
      if (wr_mask) begin
         d.mask = i_bus.wdata[SSM_MASK_W-1:0];
      end

      // Reserved detect mask codes 01 and 10 are treated as disabled
      irq_en[SSM_PWR_BIT]   = q.mask[SSM_PWR_BIT];
      irq_en[SSM_CD_HI_BIT] = q.mask[SSM_CD_HI_BIT] & q.mask[SSM_CD_LO_BIT];
      irq_en[SSM_CD_LO_BIT] = q.mask[SSM_CD_HI_BIT] & q.mask[SSM_CD_LO_BIT];
      irq_en[SSM_CST_BIT]   = q.mask[SSM_CST_BIT];
      d.irq = |(q.event_f & irq_en);

      if (i_bus.rd) begin
         d.rdata = read_word(q, i_bus.addr);
      end
   end

   // ==========================================================================
   // State register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         q <= SSM_STATE_RESET;
      end else begin
         q <= d;
      end
   end

   assign o_rdata                   = q.rdata;
   assign o_status_change_interrupt = q.irq;

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   mask_upper_zero_a: assert property (i_bus.rd && i_bus.addr == SSM_OFF_MASK |=> o_rdata[31:4] == 28'h0)
      else $error("mask upper bits not zero");
   mask_store_a: assert property (wr_mask |=> q.mask == $past(i_bus.wdata[3:0]))
      else $error("mask write not stored");
   event_no_mask_a: assert property (q.mask == 4'h0 && i_socket_powered != q.pwr_prev |=> q.event_f[3])
      else $error("power event lost while masked");
   set_beats_clr_a: assert property (clr[3] && hw_set[3] |=> q.event_f[3])
      else $error("clear beat a simultaneous event");
   irq_power_a: assert property (q.event_f[3] && q.mask[3] |=> o_status_change_interrupt)
      else $error("enabled power event gave no interrupt");
   irq_cd_half_a: assert property (q.event_f[3:0] == 4'h2 && q.mask == 4'h2 |=> !o_status_change_interrupt)
      else $error("reserved detect mask code raised interrupt");
   ident_freeze_a: assert property (i_ident.busy |=> $stable(q.det_rep))
      else $error("detect level moved during identification");
   volts_hold_a: assert property (!i_ident.insert_done && !wr_force |=> $stable(q.card_v))
      else $error("card voltage bits changed between insertions");
   state_fixed_a: assert property (i_bus.rd && i_bus.addr == SSM_OFF_STATE
                                   |=> o_rdata[31:28] == 4'h3 && o_rdata[26:14] == 13'h0)
      else $error("present-state fixed bits wrong");
   cst_cardbus_a: assert property (i_ident.cardbus && !wr_force && q.lvl[2] && !d.lvl[2] && !q.event_f[0]
                                   |=> !q.event_f[0])
      else $error("falling status edge flagged for CardBus");

   irq_seen_c:    cover property (!o_status_change_interrupt ##1 o_status_change_interrupt);
   ident_move_c:  cover property (i_ident.busy && d.lvl[1:0] != q.lvl[1:0]);
   insert_c:      cover property (i_ident.insert_done ##1 i_bus.rd && i_bus.addr == SSM_OFF_STATE);

endmodule : ssm_regs

`default_nettype wire

/* File: tb/ssm_regs_test.sv */
// Self-checking bench for the socket mask and live-state register bank
`timescale 1ns/1ps
`default_nettype none
module ssm_regs_test;
   import ssm_pkg::*;
   // ==========================================================================
   // Stimulus and observation
   logic         clk;              // 10 MHz bus clock
   logic         rst_n;            // Synchronous reset, active low
   ssm_bus_req_t bus;              // Register request
   ssm_ident_t   ident;            // Identification results
   logic         cd1_n;            // Detect pin one
   logic         cd2_n;            // Detect pin two
   logic         cst;              // Card status pin
   logic         pwr;              // Socket power state
   logic [31:0]  rdata;            // Read data
   logic         irq;              // Status change interrupt
   int           fails;            // Mismatches
   int           samples_checked;  // Comparisons made
   ssm_regs ssm_regs_i (
      .i_clk                     (clk),
      .i_rst_n                   (rst_n),
      .i_bus                     (bus),
      .i_ident                   (ident),
      .i_card_detect_one_n       (cd1_n),
      .i_card_detect_two_n       (cd2_n),
      .i_card_status_change      (cst),
      .i_socket_powered          (pwr),
      .o_rdata                   (rdata),
      .o_status_change_interrupt (irq)
   );
   // ==========================================================================
   // Clock and helpers
   always #50 clk = ~clk;
   // Inputs always move 10 ns after the rising edge, well clear of sampling
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask : cyc
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus.wr    = 1'b1;
      bus.addr  = a;
      bus.wdata = d;
      cyc(1);
      bus.wr    = 1'b0;
   endtask : wr
   // Read data is sampled a full cycle later; it holds until the next read
   task automatic rd(input string what, input logic [5:0] a, input logic [31:0] exp);
      bus.rd   = 1'b1;
      bus.addr = a;
      cyc(1);
      bus.rd   = 1'b0;
      cyc(1);
      check(what, exp, rdata);
   endtask : rd
   task automatic irq_is(input logic exp);
      cyc(2);
      check("irq", {31'h0, exp}, {31'h0, irq});
   endtask : irq_is
   task automatic report_and_stop;
      $display("Checked %0d, errors %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   // ==========================================================================
   // Scenarios
   task automatic t_reset;
      rd("mask", SSM_OFF_MASK, 32'h0000_0000);
      rd("state", SSM_OFF_STATE, 32'h3000_0000);
      rd("unmapped", 6'h10, 32'h0000_0000);
      wr(SSM_OFF_MASK, 32'hFFFF_FFFF);
      rd("mask", SSM_OFF_MASK, 32'h0000_000F);
      wr(SSM_OFF_MASK, 32'h0000_0000);
   endtask : t_reset
   task automatic t_power;
      pwr = 1'b1;
      cyc(3);
      rd("event", SSM_OFF_EVENT, 32'h0000_0008);
      irq_is(1'b0);
      rd("state", SSM_OFF_STATE, 32'h3000_0008);
      wr(SSM_OFF_MASK, 32'h0000_0008);
      irq_is(1'b1);
      wr(SSM_OFF_EVENT, 32'h0000_0008);
      irq_is(1'b0);
   endtask : t_power
   task automatic t_detect;
      // Reserved codes 01 and 10 are held disabled
      wr(SSM_OFF_MASK, 32'h0000_0002);
      cd1_n = 1'b1;
      cyc(6);
      rd("event", SSM_OFF_EVENT, 32'h0000_0002);
      irq_is(1'b0);
      wr(SSM_OFF_MASK, 32'h0000_0004);
      irq_is(1'b0);
      wr(SSM_OFF_MASK, 32'h0000_0006);
      irq_is(1'b1);
      rd("state", SSM_OFF_STATE, 32'h3000_000A);
      wr(SSM_OFF_EVENT, 32'h0000_0002);
      irq_is(1'b0);
   endtask : t_detect
   task automatic t_status;
      wr(SSM_OFF_MASK, 32'h0000_0001);
      ident.cardbus = 1'b1;
      cst = 1'b1;
      cyc(6);
      rd("event", SSM_OFF_EVENT, 32'h0000_0001);
      irq_is(1'b1);
      wr(SSM_OFF_EVENT, 32'h0000_0001);
      cst = 1'b0;
      cyc(6);
      rd("event", SSM_OFF_EVENT, 32'h0000_0000);
      ident.cardbus = 1'b0;
      cst = 1'b1;
      cyc(6);
      rd("event", SSM_OFF_EVENT, 32'h0000_0001);
      wr(SSM_OFF_EVENT, 32'h0000_000F);
      // A 16-bit card also flags the falling edge
      cst = 1'b0;
      cyc(6);
      rd("event", SSM_OFF_EVENT, 32'h0000_0001);
      cst = 1'b1;
      cyc(6);
      // A clock edge between writes keeps the strobe from being assigned twice in one step
      wr(SSM_OFF_EVENT, 32'h0000_000F);
      cyc(1);
      wr(SSM_OFF_MASK, 32'h0000_0000);
      cyc(1);
   endtask : t_status
   task automatic t_force_ident;
      wr(SSM_OFF_FORCE, 32'h0800_3800);
      rd("state", SSM_OFF_STATE, 32'h3800_380B);
      ident.card_volts = 3'b001;
      cyc(3);
      rd("state", SSM_OFF_STATE, 32'h3800_380B);
      ident.insert_done = 1'b1;
      cyc(1);
      ident.insert_done = 1'b0;
      rd("state", SSM_OFF_STATE, 32'h3800_080B);
      // Detect pin moves while identification runs
      ident.busy = 1'b1;
      cd2_n = 1'b1;
      cyc(6);
      rd("state", SSM_OFF_STATE, 32'h3800_080B);
      rd("event", SSM_OFF_EVENT, 32'h0000_0000);
      ident.busy = 1'b0;
      cyc(6);
      rd("state", SSM_OFF_STATE, 32'h3800_080F);
      rd("event", SSM_OFF_EVENT, 32'h0000_0004);
   endtask : t_force_ident
   // Bus reset in mid-run: flags, mask and interrupt clear; pins match reset levels so nothing re-arms
   task automatic t_midreset;
      pwr   = 1'b0;
      cd1_n = 1'b0;
      cd2_n = 1'b0;
      cst   = 1'b0;
      cyc(6);
      wr(SSM_OFF_FORCE, 32'h0000_000F);
      cyc(1);
      wr(SSM_OFF_MASK, 32'h0000_000F);
      irq_is(1'b1);
      rd("event", SSM_OFF_EVENT, 32'h0000_000F);
      rst_n = 1'b0;
      cyc(4);
      rst_n = 1'b1;
      irq_is(1'b0);
      rd("event", SSM_OFF_EVENT, 32'h0000_0000);
      rd("mask", SSM_OFF_MASK, 32'h0000_0000);
      rd("state", SSM_OFF_STATE, 32'h3000_0000);
   endtask : t_midreset
   // ==========================================================================
   // Main sequence and hang guard
   initial begin
      #3_000_000;
      fails++;
      report_and_stop();
   end
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      bus = '0;
      ident = '0;
      cd1_n = 1'b0;
      cd2_n = 1'b0;
      cst = 1'b0;
      pwr = 1'b0;
      fails = 0;
      samples_checked = 0;
      cyc(16);
      rst_n = 1'b1;
      cyc(2);
      t_reset();
      t_power();
      t_detect();
      t_status();
      t_force_ident();
      t_midreset();
      report_and_stop();
   end
endmodule : ssm_regs_test
`default_nettype wire
